/* File: hw/ntpd_cfg.svh */
// constants of the native telegram process data mapper
`ifndef NTPD_CFG_SVH
`define NTPD_CFG_SVH

// telegram numbers
`define NTPD_TEL_100        8'h64
`define NTPD_TEL_101        8'h65
`define NTPD_TEL_102        8'h66
`define NTPD_TEL_106        8'h6a
`define NTPD_TEL_107        8'h6b
`define NTPD_TEL_RESET      8'h64

// cyclic slot counts per direction
`define NTPD_SLOTS_100      5'h02
`define NTPD_SLOTS_101      5'h06
`define NTPD_SLOTS_106      5'h08
`define NTPD_SLOTS_107      5'h10

// parameter channel length in words
`define NTPD_PC_WORDS       5'h04

// default bindings: 8501, 8602 command side, 3201, 8604 monitor side
`define NTPD_CMD1_DEF       16'h2135
`define NTPD_CMD2_DEF       16'h219a
`define NTPD_MON1_DEF       16'h0c81
`define NTPD_MON2_DEF       16'h219c
`define NTPD_UNLINKED       16'h0000

// binding table index layout: {monitor, slot[3:0]}
`define NTPD_TAB_DEPTH      32
`define NTPD_MON_BIT        4

// request codes
`define NTPD_REQ_NONE       16'h0000
`define NTPD_REQ_READ       16'h0001
`define NTPD_REQ_WR16       16'h0002
`define NTPD_REQ_WR32       16'h0003

// response codes
`define NTPD_RSP_NONE       16'h0000
`define NTPD_RSP_RD16       16'h0001
`define NTPD_RSP_WR16       16'h0002
`define NTPD_RSP_BUSY       16'h0003
`define NTPD_RSP_WR32       16'h0005
`define NTPD_RSP_ERR        16'h0007

`endif

/* File: hw/ntpd_pkg.sv */
// types of the native telegram process data mapper
package ntpd_pkg;

    typedef enum logic [5:0] {
        NTPD_TX_IDLE  = 6'h01,
        NTPD_TX_PC    = 6'h02,
        NTPD_TX_LOOK  = 6'h04,
        NTPD_TX_FETCH = 6'h08,
        NTPD_TX_WAIT  = 6'h10,
        NTPD_TX_EMIT  = 6'h20
    } ntpd_tx_state_t;

    typedef enum logic [2:0] {
        NTPD_PR_IDLE   = 3'h1,
        NTPD_PR_BUSY   = 3'h2,
        NTPD_PR_SECOND = 3'h4
    } ntpd_pr_state_t;

endpackage : ntpd_pkg

/* File: hw/ntpd_bind_if.sv */
// carrier between the mapper and its slot binding table
`timescale 1ns/1ps
`default_nettype none

interface ntpd_bind_if;
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [15:0] wr_addr;
    logic [4:0]  ra_idx;
    logic [15:0] ra_data;
    logic [4:0]  rb_idx;
    logic [15:0] rb_data;

    modport mem  (input wr_en, wr_idx, wr_addr, ra_idx, rb_idx, output ra_data, rb_data);
    modport user (output wr_en, wr_idx, wr_addr, ra_idx, rb_idx, input ra_data, rb_data);
endinterface : ntpd_bind_if

`default_nettype wire

/* File: hw/ntpd_bind_mem.sv */
// slot binding table: 16 command and 16 monitor modbus addresses
`timescale 1ns/1ps
`default_nettype none
`include "ntpd_cfg.svh"

module ntpd_bind_mem (
    input wire logic   core_clk,
    input wire logic   resetn,
    ntpd_bind_if.mem   bus
);
    logic [15:0] tab [`NTPD_TAB_DEPTH];

    // one entry per slot; reset restores the factory bindings
    for (genvar i = 0; i < `NTPD_TAB_DEPTH; i++) begin : g_ent
        localparam logic [15:0] DEF = (i == 0)  ? `NTPD_CMD1_DEF :
                                      (i == 1)  ? `NTPD_CMD2_DEF :
                                      (i == 16) ? `NTPD_MON1_DEF :
                                      (i == 17) ? `NTPD_MON2_DEF : `NTPD_UNLINKED;
        always_ff @(posedge core_clk) begin
            if (!resetn) begin
                tab[i] <= DEF;
            end else if (bus.wr_en && bus.wr_idx == 5'(i)) begin
                tab[i] <= bus.wr_addr;
            end
        end
    end

    // both read ports are registered, one cycle after the index
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bus.ra_data <= 16'h0000;
            bus.rb_data <= 16'h0000;
        end else begin
            bus.ra_data <= tab[bus.ra_idx];
            bus.rb_data <= tab[bus.rb_idx];
        end
    end
endmodule : ntpd_bind_mem

`default_nettype wire

/* File: hw/ntpd_mapper.sv */
// native telegram process data mapper: frame unpack, frame build, parameter channel
`timescale 1ns/1ps
`default_nettype none
`include "ntpd_cfg.svh"

module ntpd_mapper (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  tel_sel,
    input  wire logic        cfg_we,
    input  wire logic        cfg_monitor,
    input  wire logic [3:0]  cfg_slot,
    input  wire logic [15:0] cfg_addr,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic [15:0] rx_data,
    input  wire logic        tx_start,
    output logic             tx_valid,
    output logic             tx_sof,
    output logic             tx_last,
    output logic [15:0]      tx_data,
    output logic             db_wr_valid,
    output logic [15:0]      db_wr_addr,
    output logic [15:0]      db_wr_data,
    output logic             db_rd_req,
    output logic [15:0]      db_rd_addr,
    input  wire logic [15:0] db_rd_data,
    output logic             pr_req,
    output logic             pr_write,
    output logic [15:0]      pr_addr,
    output logic [15:0]      pr_data,
    input  wire logic        pr_done,
    input  wire logic        pr_err,
    input  wire logic [15:0] pr_rdata,
    output logic [7:0]       active_tel
);
    ntpd_bind_if bind_bus ();

    ntpd_bind_mem u_tab (
        .core_clk (core_clk),
        .resetn   (resetn),
        .bus      (bind_bus.mem)
    );

    logic                    tel_taken_reg;
    logic                    has_pc;
    logic [4:0]              nslots;
    logic [4:0]              pc_off;
    logic [4:0]              rx_idx_reg;
    logic [4:0]              rx_idx;
    logic [4:0]              rx_slot;
    logic                    rx_pend_reg;
    logic [15:0]             rx_data_reg;
    logic [15:0]             req_addr_reg;
    logic [15:0]             req_code_reg;
    logic [15:0]             req_hi_reg;
    logic                    pc_full;
    logic [15:0]             last_addr_reg;
    logic [15:0]             last_code_reg;
    logic [15:0]             rsp_addr_reg;
    logic [15:0]             rsp_code_reg;
    logic [15:0]             rsp_hi_reg;
    logic [15:0]             rsp_lo_reg;
    logic [15:0]             low_val_reg;
    ntpd_pkg::ntpd_pr_state_t pr_state_reg;
    ntpd_pkg::ntpd_tx_state_t tx_state_reg;
    logic [1:0]              tx_pc_reg;
    logic [3:0]              tx_slot_reg;
    logic                    tx_first_reg;
    logic                    linked_reg;

    // restart latch: telegram sampled once after reset, later changes ignored
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tel_taken_reg <= 1'b0;
            active_tel    <= `NTPD_TEL_RESET;
        end else if (!tel_taken_reg) begin
            tel_taken_reg <= 1'b1;
            active_tel    <= tel_sel;
        end
    end

    // layout of the active telegram; unknown numbers fall back to the 100 layout
    always_comb begin
        has_pc = 1'b1;
        nslots = `NTPD_SLOTS_100;
        case (active_tel)
            `NTPD_TEL_101: nslots = `NTPD_SLOTS_101;
            `NTPD_TEL_102: begin
                has_pc = 1'b0;
                nslots = `NTPD_SLOTS_101;
            end
            `NTPD_TEL_106: nslots = `NTPD_SLOTS_106;
            `NTPD_TEL_107: nslots = `NTPD_SLOTS_107;
            default:       nslots = `NTPD_SLOTS_100;
        endcase
        pc_off = has_pc ? `NTPD_PC_WORDS : 5'h00;
    end

    // inbound word position; sof restarts the count, excess words fall off the end
    always_comb begin
        rx_idx  = rx_sof ? 5'h00 : rx_idx_reg;
        rx_slot = rx_idx - pc_off;
        pc_full = rx_valid && has_pc && rx_idx == 5'h03;
    end

    // binding table access: config writes, inbound lookup on port a, outbound on b
    assign bind_bus.wr_en   = cfg_we;
    assign bind_bus.wr_idx  = {cfg_monitor, cfg_slot};
    assign bind_bus.wr_addr = cfg_addr;
    assign bind_bus.ra_idx  = {1'b0, rx_slot[3:0]};
    assign bind_bus.rb_idx  = {1'b1, tx_slot_reg};

    // inbound frame: capture channel words, queue slot words for lookup
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_idx_reg   <= 5'h00;
            rx_pend_reg  <= 1'b0;
            rx_data_reg  <= 16'h0000;
            req_addr_reg <= 16'h0000;
            req_code_reg <= 16'h0000;
            req_hi_reg   <= 16'h0000;
        end else begin
            rx_pend_reg <= 1'b0;
            if (rx_valid) begin
                rx_idx_reg <= (rx_idx == 5'h1f) ? rx_idx : rx_idx + 5'h01;
                if (has_pc && rx_idx == 5'h00) req_addr_reg <= rx_data;
                if (has_pc && rx_idx == 5'h01) req_code_reg <= rx_data;
                if (has_pc && rx_idx == 5'h02) req_hi_reg   <= rx_data;
                // slot words keep their positions whether linked or not
                if (rx_idx >= pc_off && rx_slot < nslots) begin
                    rx_pend_reg <= 1'b1;
                    rx_data_reg <= rx_data;
                end
            end
        end
    end

    // inbound slot to parameter database; address zero means the word is dropped
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            db_wr_valid <= 1'b0;
            db_wr_addr  <= 16'h0000;
            db_wr_data  <= 16'h0000;
        end else begin
            db_wr_valid <= rx_pend_reg && bind_bus.ra_data != `NTPD_UNLINKED;
            db_wr_addr  <= bind_bus.ra_data;
            db_wr_data  <= rx_data_reg;
        end
    end

    // parameter channel: a request runs when address or code changes from the last one;
    // resending the same request every frame would otherwise repeat writes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pr_state_reg  <= ntpd_pkg::NTPD_PR_IDLE;
            pr_req        <= 1'b0;
            pr_write      <= 1'b0;
            pr_addr       <= 16'h0000;
            pr_data       <= 16'h0000;
            last_addr_reg <= 16'h0000;
            last_code_reg <= 16'h0000;
            low_val_reg   <= 16'h0000;
            rsp_addr_reg  <= 16'h0000;
            rsp_code_reg  <= `NTPD_RSP_NONE;
            rsp_hi_reg    <= 16'h0000;
            rsp_lo_reg    <= 16'h0000;
        end else begin
            case (pr_state_reg)
                ntpd_pkg::NTPD_PR_IDLE: begin
                    if (pc_full && (req_addr_reg != last_addr_reg
                                    || req_code_reg != last_code_reg)) begin
                        last_addr_reg <= req_addr_reg;
                        last_code_reg <= req_code_reg;
                        rsp_addr_reg  <= req_addr_reg;
                        rsp_hi_reg    <= 16'h0000;
                        rsp_lo_reg    <= 16'h0000;
                        low_val_reg   <= rx_data;
                        pr_addr       <= req_addr_reg;
                        pr_write      <= req_code_reg != `NTPD_REQ_READ;
                        // 32-bit write sends the high word first
                        pr_data       <= (req_code_reg == `NTPD_REQ_WR32) ? req_hi_reg
                                                                          : rx_data;
                        if (req_code_reg == `NTPD_REQ_NONE) begin
                            rsp_code_reg <= `NTPD_RSP_NONE;
                        end else if (req_code_reg > `NTPD_REQ_WR32
                                     || req_addr_reg == 16'h0000) begin
                            rsp_code_reg <= `NTPD_RSP_ERR;
                        end else begin
                            rsp_code_reg <= `NTPD_RSP_BUSY;
                            pr_req       <= 1'b1;
                            pr_state_reg <= ntpd_pkg::NTPD_PR_BUSY;
                        end
                    end
                end
                ntpd_pkg::NTPD_PR_BUSY: begin
                    if (pr_done) begin
                        pr_req       <= 1'b0;
                        pr_state_reg <= ntpd_pkg::NTPD_PR_IDLE;
                        if (pr_err) begin
                            rsp_code_reg <= `NTPD_RSP_ERR;
                        end else if (last_code_reg == `NTPD_REQ_READ) begin
                            rsp_code_reg <= `NTPD_RSP_RD16;
                            rsp_lo_reg   <= pr_rdata;
                        end else if (last_code_reg == `NTPD_REQ_WR16) begin
                            rsp_code_reg <= `NTPD_RSP_WR16;
                            rsp_lo_reg   <= pr_data;
                        end else begin
                            pr_req       <= 1'b1;                      // low half next
                            pr_addr      <= pr_addr + 16'h0001;
                            pr_data      <= low_val_reg;
                            pr_state_reg <= ntpd_pkg::NTPD_PR_SECOND;
                        end
                    end
                end
                ntpd_pkg::NTPD_PR_SECOND: begin
                    if (pr_done) begin
                        pr_req       <= 1'b0;
                        pr_state_reg <= ntpd_pkg::NTPD_PR_IDLE;
                        rsp_code_reg <= pr_err ? `NTPD_RSP_ERR : `NTPD_RSP_WR32;
                        rsp_hi_reg   <= pr_err ? 16'h0000 : req_hi_reg;
                        rsp_lo_reg   <= pr_err ? 16'h0000 : low_val_reg;
                    end
                end
                default: pr_state_reg <= ntpd_pkg::NTPD_PR_IDLE;
            endcase
        end
    end

    // outbound frame: four cycles per slot (look, fetch, wait, emit)
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tx_state_reg <= ntpd_pkg::NTPD_TX_IDLE;
            tx_pc_reg    <= 2'h0;
            tx_slot_reg  <= 4'h0;
            tx_first_reg <= 1'b0;
            linked_reg   <= 1'b0;
            tx_valid     <= 1'b0;
            tx_sof       <= 1'b0;
            tx_last      <= 1'b0;
            tx_data      <= 16'h0000;
            db_rd_req    <= 1'b0;
            db_rd_addr   <= 16'h0000;
        end else begin
            tx_valid  <= 1'b0;
            tx_sof    <= 1'b0;
            tx_last   <= 1'b0;
            db_rd_req <= 1'b0;
            case (tx_state_reg)
                ntpd_pkg::NTPD_TX_IDLE: begin
                    tx_pc_reg    <= 2'h0;
                    tx_slot_reg  <= 4'h0;
                    tx_first_reg <= 1'b1;
                    if (tx_start) begin
                        tx_state_reg <= has_pc ? ntpd_pkg::NTPD_TX_PC
                                               : ntpd_pkg::NTPD_TX_LOOK;
                    end
                end
                ntpd_pkg::NTPD_TX_PC: begin
                    tx_valid     <= 1'b1;
                    tx_sof       <= tx_first_reg;
                    tx_first_reg <= 1'b0;
                    case (tx_pc_reg)
                        2'h0:    tx_data <= rsp_addr_reg;
                        2'h1:    tx_data <= rsp_code_reg;
                        2'h2:    tx_data <= rsp_hi_reg;
                        default: tx_data <= rsp_lo_reg;
                    endcase
                    tx_pc_reg <= tx_pc_reg + 2'h1;
                    if (tx_pc_reg == 2'h3) tx_state_reg <= ntpd_pkg::NTPD_TX_LOOK;
                end
                ntpd_pkg::NTPD_TX_LOOK: tx_state_reg <= ntpd_pkg::NTPD_TX_FETCH;
                ntpd_pkg::NTPD_TX_FETCH: begin
                    linked_reg   <= bind_bus.rb_data != `NTPD_UNLINKED;
                    db_rd_req    <= bind_bus.rb_data != `NTPD_UNLINKED;
                    db_rd_addr   <= bind_bus.rb_data;
                    tx_state_reg <= ntpd_pkg::NTPD_TX_WAIT;
                end
                ntpd_pkg::NTPD_TX_WAIT: tx_state_reg <= ntpd_pkg::NTPD_TX_EMIT;
                ntpd_pkg::NTPD_TX_EMIT: begin
                    // unlinked slot still takes its place, carrying zero
                    tx_valid     <= 1'b1;
                    tx_data      <= linked_reg ? db_rd_data : 16'h0000;
                    tx_sof       <= tx_first_reg;
                    tx_first_reg <= 1'b0;
                    if ({1'b0, tx_slot_reg} == nslots - 5'h01) begin
                        tx_last      <= 1'b1;
                        tx_state_reg <= ntpd_pkg::NTPD_TX_IDLE;
                    end else begin
                        tx_slot_reg  <= tx_slot_reg + 4'h1;
                        tx_state_reg <= ntpd_pkg::NTPD_TX_LOOK;
                    end
                end
                default: tx_state_reg <= ntpd_pkg::NTPD_TX_IDLE;
            endcase
        end
    end
endmodule : ntpd_mapper

`default_nettype wire

/* File: tb/ntpd_mapper_assertions.sv */
// checker: port-level timing and framing properties of the mapper
`timescale 1ns/1ps
`default_nettype none

module ntpd_mapper_assertions (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        rx_valid,
    input wire logic        tx_start,
    input wire logic        tx_valid,
    input wire logic        tx_sof,
    input wire logic        tx_last,
    input wire logic        db_wr_valid,
    input wire logic [15:0] db_wr_addr,
    input wire logic        db_rd_req,
    input wire logic        pr_req,
    input wire logic [15:0] pr_addr,
    input wire logic        pr_done,
    input wire logic [7:0]  active_tel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic       busy_reg;
    logic [4:0] wcnt_reg, pc_w, len_w;

    // channel and frame length of the latched layout
    always_comb begin
        pc_w = (active_tel == 8'h66) ? 5'h00 : 5'h04;
        case (active_tel)
            8'h65, 8'h66: len_w = pc_w + 5'h06;
            8'h6a:        len_w = pc_w + 5'h08;
            8'h6b:        len_w = pc_w + 5'h10;
            default:      len_w = pc_w + 5'h02;
        endcase
    end

    // busy from an accepted start to the last word; words sent so far
    always_ff @(posedge core_clk) begin
        if (!resetn || (tx_valid && tx_last)) begin
            busy_reg <= 1'b0;
            wcnt_reg <= 5'h00;
        end else begin
            busy_reg <= busy_reg || tx_start;
            wcnt_reg <= wcnt_reg + 5'(tx_valid);
        end
    end

    sequence s_pc_head;
        (tx_valid && tx_sof) ##1 tx_valid [*3];
    endsequence
    sequence s_slot_gap;
        !tx_valid [*3] ##1 tx_valid;
    endsequence

    property p_tel_hold;
        $past(resetn, 2) |-> $stable(active_tel);
    endproperty
    property p_first_pc;
        tx_start && !busy_reg && active_tel != 8'h66 |=> !tx_valid ##1 s_pc_head;
    endproperty
    property p_first_102;
        tx_start && !busy_reg && active_tel == 8'h66 |=> !tx_valid [*4] ##1 (tx_valid && tx_sof);
    endproperty
    property p_slot_gap;
        tx_valid && !tx_last && wcnt_reg >= pc_w |=> s_slot_gap;
    endproperty
    property p_len;
        tx_valid && tx_last |-> wcnt_reg + 5'h01 == len_w;
    endproperty
    property p_rd_emit;
        db_rd_req |-> ##2 tx_valid;
    endproperty
    property p_wr_link;
        db_wr_valid |-> db_wr_addr != 16'h0000 && $past(rx_valid, 2);
    endproperty
    property p_pr_hold;
        pr_req && !pr_done |=> pr_req && $stable(pr_addr);
    endproperty
    property p_pr_cause;
        $rose(pr_req) |-> $past(rx_valid);
    endproperty

    a_tel_hold: assert property (p_tel_hold) else $error("telegram changed without restart");
    a_first_pc: assert property (p_first_pc) else $error("channel words misplaced");
    a_first_102: assert property (p_first_102) else $error("first slot word late");
    a_slot_gap: assert property (p_slot_gap) else $error("slot word spacing wrong");
    a_len: assert property (p_len) else $error("frame length wrong");
    a_rd_emit: assert property (p_rd_emit) else $error("read not emitted");
    a_wr_link: assert property (p_wr_link) else $error("stray write");
    a_pr_hold: assert property (p_pr_hold) else $error("request dropped early");
    a_pr_cause: assert property (p_pr_cause) else $error("stray request");
endmodule : ntpd_mapper_assertions

bind ntpd_mapper ntpd_mapper_assertions u_chk (.core_clk, .resetn, .rx_valid, .tx_start,
    .tx_valid, .tx_sof, .tx_last, .db_wr_valid, .db_wr_addr, .db_rd_req, .pr_req, .pr_addr,
    .pr_done, .active_tel);

`default_nettype wire

/* File: tb/ntpd_db_model.sv */
// far-side model: drive parameter database, prompt or slow
`timescale 1ns/1ps
`default_nettype none

module ntpd_db_model (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        db_rd_req,
    input wire logic [15:0] db_rd_addr,
    output logic     [15:0] db_rd_data,
    input wire logic        pr_req,
    input wire logic [15:0] pr_addr,
    output logic            pr_done,
    output logic            pr_err,
    output logic     [15:0] pr_rdata,
    input wire logic        fail,
    input wire logic        slow
);
    int wait_cnt;

    // data valid only the cycle after a read; a moving pattern otherwise
    always @(posedge core_clk) begin
        if (!resetn) db_rd_data <= 16'h5a5a;
        else if (db_rd_req) db_rd_data <= db_rd_addr ^ 16'h3c5a;
        else db_rd_data <= ~db_rd_data;
    end

    // one completion per request; slow mode exercises the busy answer
    always @(posedge core_clk) begin
        if (!resetn) begin
            pr_done <= 1'b0;
            pr_err <= 1'b0;
            pr_rdata <= 16'h0f0f;
            wait_cnt <= 0;
        end else if (!pr_req || pr_done) begin
            pr_done <= 1'b0;
            pr_err <= 1'b0;
            pr_rdata <= ~pr_rdata;
            wait_cnt <= 0;
        end else if (wait_cnt >= (slow ? 6 : 0)) begin
            pr_done <= 1'b1;
            pr_err <= fail;
            pr_rdata <= pr_addr ^ 16'h3c5a;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule : ntpd_db_model

`default_nettype wire

/* File: tb/ntpd_mapper_tb.sv */
// self-checking bench of the process data mapper
`timescale 1ns/1ps
`default_nettype none

module ntpd_mapper_tb;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  tel_sel = 8'h64;
    logic        cfg_we = 1'b0;
    logic        cfg_monitor = 1'b0;
    logic [3:0]  cfg_slot = 4'h0;
    logic [15:0] cfg_addr = 16'h0000;
    logic        rx_valid = 1'b0;
    logic        rx_sof = 1'b0;
    logic [15:0] rx_data = 16'h0000;
    logic        tx_start = 1'b0;
    logic        mdl_fail = 1'b0;
    logic        mdl_slow = 1'b0;
    logic        tx_valid, tx_sof, tx_last, db_wr_valid, db_rd_req, pr_req, pr_write;
    logic        pr_done, pr_err;
    logic [15:0] tx_data, db_wr_addr, db_wr_data, db_rd_addr, db_rd_data, pr_addr, pr_data;
    logic [15:0] pr_rdata;
    logic [7:0]  active_tel;
    int          err_total = 0;
    int          n_tests = 0;
    int          cmd_b[16];
    int          mon_b[16];
    logic [15:0] fq[$];
    logic [31:0] wr_q[$];
    logic [31:0] pw_q[$];
    logic [7:0]  tels[5] = '{8'h64, 8'h65, 8'h66, 8'h6a, 8'h6b};
    int          ns[5] = '{2, 6, 6, 8, 16};
    logic [15:0] pa[7] = '{16'h1234, 16'h1235, 16'h1236, 16'h1237, 16'h1238, 16'h0000, 16'h1239};
    logic [15:0] pcode[7] = '{16'h0001, 16'h0002, 16'h0003, 16'h0001, 16'h0009, 16'h0001, 16'h0000};
    logic [15:0] pe[7] = '{16'h0001, 16'h0002, 16'h0005, 16'h0007, 16'h0007, 16'h0007, 16'h0000};

    always #10 core_clk = ~core_clk;

    ntpd_mapper dut (.core_clk, .resetn, .tel_sel, .cfg_we, .cfg_monitor, .cfg_slot, .cfg_addr,
        .rx_valid, .rx_sof, .rx_data, .tx_start, .tx_valid, .tx_sof, .tx_last, .tx_data,
        .db_wr_valid, .db_wr_addr, .db_wr_data, .db_rd_req, .db_rd_addr, .db_rd_data,
        .pr_req, .pr_write, .pr_addr, .pr_data, .pr_done, .pr_err, .pr_rdata, .active_tel);

    ntpd_db_model u_db (.core_clk, .resetn, .db_rd_req, .db_rd_addr, .db_rd_data, .pr_req,
        .pr_addr, .pr_done, .pr_err, .pr_rdata, .fail(mdl_fail), .slow(mdl_slow));

    // capture writes leaving the block at mid-cycle, where settled
    always @(negedge core_clk) begin
        if (db_wr_valid === 1'b1) wr_q.push_back({db_wr_addr, db_wr_data});
        if (pr_done === 1'b1 && pr_write === 1'b1) pw_q.push_back({pr_addr, pr_data});
    end

    function automatic logic [15:0] exp_mon(input int k);
        return (mon_b[k] == 0) ? 16'h0000 : 16'(mon_b[k]) ^ 16'h3c5a;
    endfunction : exp_mon

    task automatic chk(input logic [15:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // restart with a telegram, then move the selector to show it is ignored
    task automatic do_reset(input logic [7:0] tel);
        resetn <= 1'b0;
        tel_sel <= tel;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        tel_sel <= tel ^ 8'h0f;
        @(posedge core_clk);
        cmd_b = '{0: 'h2135, 1: 'h219a, default: 0};  // 8501, 8602
        mon_b = '{0: 'h0c81, 1: 'h219c, default: 0};  // 3201, 8604
    endtask : do_reset

    task automatic bind_slot(input logic mon, input logic [3:0] slot, input logic [15:0] a);
        cfg_we <= 1'b1;
        cfg_monitor <= mon;
        cfg_slot <= slot;
        cfg_addr <= a;
        @(posedge core_clk);
        if (mon) mon_b[slot] = int'(a);
        else cmd_b[slot] = int'(a);
    endtask : bind_slot

    task automatic send(input logic [15:0] w[$]);
        foreach (w[i]) begin
            rx_valid <= 1'b1;
            rx_sof <= (i == 0);
            rx_data <= w[i];
            @(posedge core_clk);
        end
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
    endtask : send

    // one outbound frame into fq; a frame that never ends stops the run
    task automatic get_frame;
        int n;
        fq = {};
        cfg_we <= 1'b0;
        tx_start <= 1'b1;
        @(posedge core_clk);
        tx_start <= 1'b0;
        for (n = 0; n < 200; n++) begin
            @(negedge core_clk);
            if (tx_valid === 1'b1) fq.push_back(tx_data);
            if (tx_valid === 1'b1 && tx_last === 1'b1) break;
        end
        @(posedge core_clk);
        if (n == 200) begin
            err_total++;
            $display("Error at %0t: frame never ended", $time);
            results();
        end
    endtask : get_frame

    initial begin
        int          pc;
        int          n;
        logic [15:0] lo;
        logic [15:0] w[$];
        logic [31:0] ew[$];
        void'($urandom(32'hd32f));
        for (int t = 0; t < 5; t++) begin
            do_reset(tels[t]);
            pc = (t == 2) ? 0 : 4;
            bind_slot(1'b1, 4'h2, 16'($urandom_range(65535, 1)));
            bind_slot(1'b0, 4'h2, 16'($urandom_range(65535, 1)));
            get_frame();
            chk(16'(fq.size()), 16'(pc + ns[t]), "frame length");
            foreach (fq[i]) chk(fq[i], (i < pc) ? 16'h0000 : exp_mon(i - pc), "out word");
            w = {};
            ew = {};
            for (int i = 0; i < pc + ns[t] + 2; i++) w.push_back((i < pc) ? 16'h0000 : 16'($urandom));
            for (int k = 0; k < ns[t]; k++) begin
                if (cmd_b[k] != 0) ew.push_back({16'(cmd_b[k]), w[pc + k]});
            end
            wr_q = {};
            send(w);
            repeat (4) @(posedge core_clk);
            chk(16'(wr_q.size()), 16'(ew.size()), "write count");
            foreach (ew[i]) chk(wr_q[i][31:16], ew[i][31:16], "write address");
            foreach (ew[i]) chk(wr_q[i][15:0], ew[i][15:0], "write data");
            chk({8'h00, active_tel}, {8'h00, tels[t]}, "active telegram");
        end
        do_reset(8'h64);
        foreach (pa[j]) begin
            mdl_fail <= (j == 3);
            mdl_slow <= j[0];
            lo = 16'($urandom);
            pw_q = {};
            w = {pa[j], pcode[j], 16'h0011, lo, 16'h0000, 16'h0000};
            send(w);
            for (n = 0; n < 12; n++) begin
                get_frame();
                if (fq[1] !== 16'h0003) break;
            end
            chk(fq[0], pa[j], "echoed address");
            chk(fq[1], pe[j], "response code");
            if (pe[j] == 16'h0001) chk(fq[3], pa[j] ^ 16'h3c5a, "read value");
            if (pe[j] == 16'h0002 || pe[j] == 16'h0005) chk(fq[3], lo, "written value");
            if (pe[j] == 16'h0005) chk(pw_q[1][31:16], pa[j] + 16'h0001, "second address");
            if (pe[j] == 16'h0005) chk(pw_q[0][15:0], 16'h0011, "first half");
        end
        results();
    end
endmodule : ntpd_mapper_tb

`default_nettype wire
